// [verilog/sine_feeder_pkg.sv]
// Shared constants and carrier types for the timed sine table converter feeder
package sine_feeder_pkg;

  // Register bus geometry (byte addresses, one 32-bit word each except the table window at OFS_TABLE)
  localparam int          ADDR_W        = 11;
  localparam logic [10:0] OFS_CTRL      = 11'h000;
  localparam logic [10:0] OFS_STATUS    = 11'h004;
  localparam logic [10:0] OFS_MASK      = 11'h008;
  localparam logic [10:0] OFS_CONV      = 11'h00C;
  localparam logic [10:0] OFS_SRC       = 11'h010;
  localparam logic [10:0] OFS_DST       = 11'h014;
  localparam logic [10:0] OFS_COUNT     = 11'h018;
  localparam logic [10:0] OFS_BASE      = 11'h01C;
  localparam logic [10:0] OFS_DESC      = 11'h020;
  localparam logic [10:0] OFS_OUT       = 11'h024;
  localparam logic [10:0] OFS_TABLE     = 11'h400;

  // Control word field positions
  localparam int CTRL_CONV_EN  = 0;
  localparam int CTRL_TMR_RUN  = 1;
  localparam int CTRL_ROUTE_EN = 2;
  localparam int CTRL_ARM      = 3;

  // Status word field positions
  localparam int ST_COUNT_END = 0;
  localparam int ST_XFER      = 1;
  localparam int ST_BLOCK_END = 2;
  localparam int ST_CONV_DONE = 3;
  localparam int STAT_W       = 4;

  // Reset values and fixed addresses
  localparam logic [7:0]  ZERO_CODE     = 8'h00;
  localparam logic [19:0] SRC_RESET     = 20'hFE000;
  localparam logic [19:0] DST_FIXED     = 20'hFFF34;
  localparam logic [7:0]  COUNT_RESET   = 8'h63;
  localparam logic [7:0]  BASE_RESET    = 8'hFD;
  localparam logic [3:0]  DESC_TOP      = 4'hF;
  localparam logic [15:0] TIMER_CMP_RST = 16'h18FF;

  // Timing: 32 MHz count source derived from the 100 MHz clock
  localparam int          CLK_NS        = 10;
  localparam int          PCLK_MHZ      = 32;
  localparam int          REFCLK_MHZ    = 100;
  localparam int          INTERVAL_US   = 200;
  localparam int          SETTLE_NS     = 1000;
  localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // Carriers
  typedef struct packed {
    logic route_en;
    logic tmr_run;
    logic conv_en;
  } ctrl_t;

  typedef struct packed {
    logic conv_done;
    logic block_end;
    logic xfer;
    logic count_end;
  } status_t;

endpackage

// [verilog/interval_timer_channel.sv]
// Interval timer channel counting a 32 MHz enable derived from the reference clock
`timescale 1ns/1ps
module interval_timer_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] cmp,
  output logic                  count_end
);

  logic [6:0]       acc_reg, acc_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             tick;
  logic             end_next;
  logic [7:0]       acc_sum;

  ////////////////////////////////////////////////////////////////////
  // Fractional accumulator: 32 ticks per 100 clocks, exact on average
  always_comb begin
    acc_sum  = {1'b0, acc_reg} + 8'(sine_feeder_pkg::PCLK_MHZ);
    tick     = acc_sum >= 8'(sine_feeder_pkg::REFCLK_MHZ);
    acc_next = tick ? 7'(acc_sum - 8'(sine_feeder_pkg::REFCLK_MHZ)) : acc_sum[6:0];
    cnt_next = cnt_reg;
    end_next = 1'b0;
    // [RULE_02] interval count end
    if (!run) begin
      acc_next = 7'h00;
      cnt_next = cmp;
    // [RULE_03] undivided count source
    end else if (tick) begin
      if (cnt_reg == '0) begin
        cnt_next = cmp;
        end_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg   <= 7'h00;
      cnt_reg   <= '0;
      count_end <= 1'b0;
    end else if (ce) begin
      acc_reg   <= acc_next;
      cnt_reg   <= cnt_next;
      count_end <= end_next;
    end
  end

endmodule

// [verilog/timed_sine_table_dac_feeder.sv]
// Timer-paced table transfer feeding an 8-bit converter, with Avalon-MM registers
//
// Behaviour
// [RULE_01] Enabling conversion drives the zero-volt code onto the output first.
// [RULE_02] Interval timer raises count end once every 200 us.
// [RULE_03] Timer counts the undivided 32 MHz peripheral clock.
// [RULE_04] Router passes timer count end to converter real-time start.
// [RULE_05] Each routed event starts converting the held conversion value.
// [RULE_06] Converted level reaches the output pin only after settling time.
// [RULE_07] The same count end activates the transfer controller once.
// [RULE_08] Each activation moves one 8-bit byte, normal mode, block size one.
// [RULE_09] Source starts at FE000 and increments after every transfer.
// [RULE_10] Destination is fixed at FFF34, the conversion value register.
// [RULE_11] Transfer count loads 99 (63H) and decrements per transfer.
// [RULE_12] Base address register holds FDH, descriptor area at FFD00H.
// [RULE_13] Read source byte, write conversion value, then advance source.
// [RULE_14] Software table holds 100 entries forming one 50 Hz period.
// [RULE_15] Entries are 127 times sine of phase plus 1.5 pi, plus 128.
// [RULE_16] Software writes zero code and configures before starting timer.
// [RULE_17] Software sets timer compare 6399 for 6400 counts per interval; here the compare is fixed by TIMER_CMP_DEFAULT instead.
// [RULE_18] At count zero the controller ignores activations until re-armed.
`timescale 1ns/1ps
module timed_sine_table_dac_feeder #(
  parameter int          TABLE_DEPTH       = 256,
  parameter int          SETTLE_CYCLES     = sine_feeder_pkg::SETTLE_CYC,
  parameter logic [15:0] TIMER_CMP_DEFAULT = sine_feeder_pkg::TIMER_CMP_RST
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [10:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [7:0]       analog_out_pin,
  output logic             irq
);

  typedef enum logic [1:0] {XF_IDLE, XF_READ, XF_WRITE} xfer_state_t;

  // Register window hit test, shared by read and write paths
  function automatic logic hit(input logic [10:0] addr, input logic [10:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic in_table(input logic [10:0] addr);
    in_table = (addr >= sine_feeder_pkg::OFS_TABLE) && (addr[1:0] == 2'b00);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State declarations
  sine_feeder_pkg::ctrl_t   ctrl_reg, ctrl_next;
  sine_feeder_pkg::status_t status_reg, status_next;
  logic [3:0]        mask_reg, mask_next;
  logic [7:0]        conv_value_reg, conv_value_next;
  logic [19:0]       transfer_source_addr_reg, src_next;
  logic [7:0]        count_reg, count_next;
  logic [7:0]        transfer_base_addr_reg, base_next;
  logic              armed_reg, armed_next;
  xfer_state_t       xf_reg, xf_next;
  logic [7:0]        held_reg, held_next;
  logic [15:0]       settle_reg, settle_next;
  logic              conv_en_d_reg;
  logic [7:0]        out_next;
  logic              irq_next;
  logic [31:0]       rdata_next;
  logic              wait_next;
  logic [3:0]        rd_clear_reg, rd_clear_next;
  logic              count_end;
  logic              route_evt;
  logic              bus_req;
  logic              bus_take;
  logic              tbl_we;
  logic [7:0]        tbl_widx;
  logic [7:0]        tbl_rd_reg;
  logic [7:0]        table_mem [TABLE_DEPTH];

  ////////////////////////////////////////////////////////////////////
  // Interval timer channel, run bit steers it
  interval_timer_channel #(
    .CNT_W (16)
  ) interval_timer_channel_i (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .run       (ctrl_reg.tmr_run),
    .cmp       (TIMER_CMP_DEFAULT),
    .count_end (count_end)
  );

  // [RULE_04] event router path
  assign route_evt = count_end && ctrl_reg.route_en && ctrl_reg.conv_en;

  // Request taken one cycle after it appears, at the waitrequest-low edge
  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;

  ////////////////////////////////////////////////////////////////////
  // Table storage: software fills it, transfer controller reads it
  always_comb begin
    tbl_widx = avs_address[9:2];
    tbl_we   = bus_take && avs_write && in_table(avs_address);
  end

  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (tbl_we) begin
        table_mem[tbl_widx] <= avs_writedata[7:0];
      end
      // Synchronous read keeps this inferable as block memory
      tbl_rd_reg <= table_mem[transfer_source_addr_reg[7:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers, bus slave, transfer controller and converter next state
  always_comb begin
    ctrl_next       = ctrl_reg;
    status_next     = status_reg;
    mask_next       = mask_reg;
    conv_value_next = conv_value_reg;
    src_next        = transfer_source_addr_reg;
    count_next      = count_reg;
    base_next       = transfer_base_addr_reg;
    armed_next      = armed_reg;
    xf_next         = xf_reg;
    held_next       = held_reg;
    settle_next     = settle_reg;
    out_next        = analog_out_pin;
    rdata_next      = avs_readdata;
    rd_clear_next   = 4'h0;
    wait_next       = 1'b1;

    // Read clear only drops bits that were returned; new events survive
    if (bus_take && avs_read && hit(avs_address, sine_feeder_pkg::OFS_STATUS)) begin
      status_next = sine_feeder_pkg::status_t'(status_next & ~rd_clear_reg);
    end

    // Bus accepts at the waitrequest-low edge
    if (bus_take && avs_write) begin
      if (hit(avs_address, sine_feeder_pkg::OFS_CTRL)) begin
        ctrl_next.conv_en  = avs_writedata[sine_feeder_pkg::CTRL_CONV_EN];
        ctrl_next.tmr_run  = avs_writedata[sine_feeder_pkg::CTRL_TMR_RUN];
        ctrl_next.route_en = avs_writedata[sine_feeder_pkg::CTRL_ROUTE_EN];
        if (avs_writedata[sine_feeder_pkg::CTRL_ARM]) begin
          armed_next = 1'b1;
        end
      end
      if (hit(avs_address, sine_feeder_pkg::OFS_MASK)) begin
        mask_next = avs_writedata[3:0];
      end
      if (hit(avs_address, sine_feeder_pkg::OFS_CONV)) begin
        conv_value_next = avs_writedata[7:0];
      end
      if (hit(avs_address, sine_feeder_pkg::OFS_SRC)) begin
        src_next = avs_writedata[19:0];
      end
      if (hit(avs_address, sine_feeder_pkg::OFS_COUNT)) begin
        count_next = avs_writedata[7:0];
      end
      if (hit(avs_address, sine_feeder_pkg::OFS_BASE)) begin
        base_next = avs_writedata[7:0];
      end
    end

    // Transfer controller
    unique case (xf_reg)
      XF_IDLE: begin
        // [RULE_07] count end activates a transfer
        // [RULE_18] exhausted count ignores activations
        if (count_end && armed_reg && count_reg != 8'h00) begin
          xf_next = XF_READ;
        end
      end
      XF_READ: begin
        xf_next = XF_WRITE;
      end
      XF_WRITE: begin
        // [RULE_08] one byte per activation
        // [RULE_10] fixed destination write
        // [RULE_13] read, write, then advance
        conv_value_next = tbl_rd_reg;
        // [RULE_09] source increments
        src_next        = transfer_source_addr_reg + 20'h00001;
        // [RULE_11] count decrements
        count_next      = count_reg - 8'h01;
        status_next.xfer = 1'b1;
        if (count_reg == 8'h01) begin
          armed_next            = 1'b0;
          status_next.block_end = 1'b1;
        end
        xf_next = XF_IDLE;
      end
      // Unused fourth code falls back to idle
      default: begin
        xf_next = XF_IDLE;
      end
    endcase

    // Converter: zero on enable, settle before the pin moves
    if (!ctrl_reg.conv_en) begin
      settle_next = 16'h0000;
      out_next    = sine_feeder_pkg::ZERO_CODE;
    end else if (!conv_en_d_reg) begin
      // [RULE_01] zero-volt start
      out_next    = sine_feeder_pkg::ZERO_CODE;
    end else if (route_evt) begin
      // [RULE_05] convert held value
      held_next   = conv_value_reg;
      settle_next = 16'(SETTLE_CYCLES);
    end else if (settle_reg != 16'h0000) begin
      settle_next = settle_reg - 16'h0001;
      // [RULE_06] settling before output
      if (settle_reg == 16'h0001) begin
        out_next              = held_reg;
        status_next.conv_done = 1'b1;
      end
    end

    // Hardware events set sticky bits; set wins over read clear
    if (count_end) begin
      status_next.count_end = 1'b1;
    end

    // Answer: capture read data on the first cycle, release after the take
    if (bus_req && avs_waitrequest) begin
      wait_next  = 1'b0;
      rdata_next = 32'h0000_0000;
      if (avs_read) begin
        if (hit(avs_address, sine_feeder_pkg::OFS_CTRL)) begin
          rdata_next[sine_feeder_pkg::CTRL_CONV_EN]  = ctrl_reg.conv_en;
          rdata_next[sine_feeder_pkg::CTRL_TMR_RUN]  = ctrl_reg.tmr_run;
          rdata_next[sine_feeder_pkg::CTRL_ROUTE_EN] = ctrl_reg.route_en;
          rdata_next[sine_feeder_pkg::CTRL_ARM]      = armed_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_STATUS)) begin
          rdata_next[sine_feeder_pkg::STAT_W-1:0] = status_reg;
          rd_clear_next                          = status_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_MASK)) begin
          rdata_next[3:0] = mask_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_CONV)) begin
          rdata_next[7:0] = conv_value_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_SRC)) begin
          rdata_next[19:0] = transfer_source_addr_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_DST)) begin
          rdata_next[19:0] = sine_feeder_pkg::DST_FIXED;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_COUNT)) begin
          rdata_next[7:0] = count_reg;
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_BASE)) begin
          rdata_next[7:0] = transfer_base_addr_reg;
        end
        // [RULE_12] descriptor area from base
        if (hit(avs_address, sine_feeder_pkg::OFS_DESC)) begin
          rdata_next[19:0] = {sine_feeder_pkg::DESC_TOP, transfer_base_addr_reg, 8'h00};
        end
        if (hit(avs_address, sine_feeder_pkg::OFS_OUT)) begin
          rdata_next[7:0] = analog_out_pin;
        end
      end
    end

    irq_next = |(status_next & mask_next);
  end

  ////////////////////////////////////////////////////////////////////
  // State registers; ce low freezes all of them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg                 <= '0;
      status_reg               <= '0;
      mask_reg                 <= 4'h0;
      conv_value_reg           <= sine_feeder_pkg::ZERO_CODE;
      transfer_source_addr_reg <= sine_feeder_pkg::SRC_RESET;
      count_reg                <= sine_feeder_pkg::COUNT_RESET;
      transfer_base_addr_reg   <= sine_feeder_pkg::BASE_RESET;
      armed_reg                <= 1'b0;
      xf_reg                   <= XF_IDLE;
      held_reg                 <= sine_feeder_pkg::ZERO_CODE;
      settle_reg               <= 16'h0000;
      conv_en_d_reg            <= 1'b0;
      rd_clear_reg             <= 4'h0;
      analog_out_pin           <= sine_feeder_pkg::ZERO_CODE;
      irq                      <= 1'b0;
      avs_readdata             <= 32'h0000_0000;
      avs_waitrequest          <= 1'b1;
    end else if (ce) begin
      ctrl_reg                 <= ctrl_next;
      status_reg               <= status_next;
      mask_reg                 <= mask_next;
      conv_value_reg           <= conv_value_next;
      transfer_source_addr_reg <= src_next;
      count_reg                <= count_next;
      transfer_base_addr_reg   <= base_next;
      armed_reg                <= armed_next;
      xf_reg                   <= xf_next;
      held_reg                 <= held_next;
      settle_reg               <= settle_next;
      conv_en_d_reg            <= ctrl_reg.conv_en;
      rd_clear_reg             <= rd_clear_next;
      analog_out_pin           <= out_next;
      irq                      <= irq_next;
      avs_readdata             <= rdata_next;
      avs_waitrequest          <= wait_next;
    end
  end

endmodule

// [tb/sine_feeder_checker.sv]
// Port-level assertions for the timed sine table converter feeder
`timescale 1ns/1ps
module sine_feeder_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [10:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  analog_out_pin,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Accepted bus cycles, seen at the edge where waitrequest is low
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_ok = avs_write && !avs_waitrequest;
  ////////////////////////////////////////////////////////////////////////
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_accept;
    ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_accept: assert property (p_accept) else $error("request not answered");
  property p_idle_wait;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low with no request");
  property p_rd_hold;
    !((avs_read || avs_write) && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a request");
  property p_dst_fixed;
    rd_ok && avs_address == sine_feeder_pkg::OFS_DST
      |-> avs_readdata == {12'h000, sine_feeder_pkg::DST_FIXED};
  endproperty
  a_dst_fixed: assert property (p_dst_fixed) else $error("destination not fixed");
  property p_desc_area;
    rd_ok && avs_address == sine_feeder_pkg::OFS_DESC
      |-> avs_readdata[19:16] == sine_feeder_pkg::DESC_TOP && avs_readdata[7:0] == 8'h00;
  endproperty
  a_desc_area: assert property (p_desc_area) else $error("descriptor area wrong");
  property p_conv_off;
    wr_ok && avs_address == sine_feeder_pkg::OFS_CTRL && !avs_writedata[0]
      |=> ##1 analog_out_pin == sine_feeder_pkg::ZERO_CODE;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("output not zero when off");
  property p_mask_off;
    wr_ok && avs_address == sine_feeder_pkg::OFS_MASK && avs_writedata[3:0] == 4'h0
      |=> ##1 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high with all masked");
  property p_table_wo;
    rd_ok && avs_address[10] |-> avs_readdata == 32'h0;
  endproperty
  a_table_wo: assert property (p_table_wo) else $error("table read not zero");
  // Main scenarios reached
  c_pin_move: cover property ($changed(analog_out_pin) && analog_out_pin != 8'h00);
  c_irq_rise: cover property ($rose(irq));
  c_rd_dst: cover property (rd_ok && avs_address == sine_feeder_pkg::OFS_DST);
endmodule

bind timed_sine_table_dac_feeder sine_feeder_checker sine_feeder_checker_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .analog_out_pin(analog_out_pin), .irq(irq));

// [tb/analog_load_model.sv]
// Load on the converter output pin, tracking the level it settles to
`timescale 1ns/1ps
module analog_load_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] analog_out_pin,
  output logic [7:0]      level
);
  // Load follows the pin one cycle late, so glitches shorter than that are lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 8'h00;
    end else begin
      level <= analog_out_pin;
    end
  end
endmodule

// [tb/timed_sine_table_dac_feeder_tb.sv]
// Self-checking bench for the timed sine table converter feeder
`timescale 1ns/1ps
module timed_sine_table_dac_feeder_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [10:0] avs_address = 11'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  analog_out_pin;
  logic        irq;
  logic [7:0]  level;
  logic [7:0]  tab [0:99];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // Short compare and settle keep the run brief
  timed_sine_table_dac_feeder #(.TABLE_DEPTH(256), .SETTLE_CYCLES(3),
    .TIMER_CMP_DEFAULT(16'h0009)) timed_sine_table_dac_feeder_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .analog_out_pin(analog_out_pin), .irq(irq));
  analog_load_model analog_load_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .analog_out_pin(analog_out_pin), .level(level));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low, then a gap edge
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // One wait cycle is the slave's fixed answer; a hang is left to the watchdog
    check("bus latency", n, 32'h2);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [10:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 200) check("irq wait", 32'h0, 32'h1);
  endtask
  // Poll status until a transfer is flagged; a hang here is a miss
  task automatic wait_xfer(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      rd(sine_feeder_pkg::OFS_STATUS, st);
      n++;
    end while (st[1] !== 1'b1 && n < 30);
    check("transfer flag", {31'h0, st[1]}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    rd(sine_feeder_pkg::OFS_SRC, q);
    check("src reset", q, 32'h000FE000);
    rd(sine_feeder_pkg::OFS_COUNT, q);
    check("count reset", q, 32'h00000063);
    rd(sine_feeder_pkg::OFS_BASE, q);
    check("base reset", q, 32'h000000FD);
    rd(sine_feeder_pkg::OFS_DESC, q);
    check("descriptor area", q, 32'h000FFD00);
    wr(sine_feeder_pkg::OFS_DST, 32'h00012345);
    rd(sine_feeder_pkg::OFS_DST, q);
    check("destination", q, 32'h000FFF34);
    wr(11'h028, 32'hFFFFFFFF);
    rd(11'h028, q);
    check("unmapped", q, 32'h0);
    rd(sine_feeder_pkg::OFS_OUT, q);
    check("output at reset", q, 32'h0);
  endtask
  task automatic t_table();
    real ph;
    logic [31:0] q;
    for (int i = 0; i < 100; i++) begin
      ph = 2.0 * 3.14159265358979 * (i / 100.0 + 0.75);
      tab[i] = 8'($rtoi(127.0 * $sin(ph) + 128.5));
      wr(sine_feeder_pkg::OFS_TABLE + 11'(4 * i), {24'h0, tab[i]});
    end
    // Table is write only from the bus
    rd(sine_feeder_pkg::OFS_TABLE, q);
    check("table write only", q, 32'h0);
  endtask
  task automatic t_timer();
    logic [31:0] q;
    int t0;
    wr(sine_feeder_pkg::OFS_CONV, 32'h0);
    wr(sine_feeder_pkg::OFS_CTRL, 32'h5);
    check("pin on enable", {24'h0, analog_out_pin}, 32'h0);
    wr(sine_feeder_pkg::OFS_MASK, 32'h1);
    wr(sine_feeder_pkg::OFS_CTRL, 32'h7);
    wait_irq(1'b1);
    t0 = cyc;
    repeat (32) begin
      rd(sine_feeder_pkg::OFS_STATUS, q);
      check("count end flag", {31'h0, q[0]}, 32'h1);
      wait_irq(1'b0);
      wait_irq(1'b1);
    end
    check("32 intervals", {31'h0, (cyc - t0) inside {[999:1001]}}, 32'h1);
    check("unarmed output", {24'h0, level}, 32'h0);
  endtask
  task automatic t_stream();
    logic [31:0] q;
    logic [31:0] st;
    logic [7:0]  prev;
    prev = sine_feeder_pkg::ZERO_CODE;
    wr(sine_feeder_pkg::OFS_MASK, 32'h0);
    wr(sine_feeder_pkg::OFS_CTRL, 32'hF);
    // Count 63H steps down to zero, so 99 transfers empty it
    for (int k = 0; k < 99; k++) begin
      wait_xfer(st);
      rd(sine_feeder_pkg::OFS_CONV, q);
      check("conv value", q, {24'h0, tab[k]});
      rd(sine_feeder_pkg::OFS_SRC, q);
      check("src step", q, 32'h000FE000 + 32'(k + 1));
      rd(sine_feeder_pkg::OFS_COUNT, q);
      check("count step", q, 32'(98 - k));
      check("settled level", {24'h0, level}, {24'h0, prev});
      prev = tab[k];
    end
    check("block end", {31'h0, st[2]}, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    // No transfer after count zero, though the timer keeps firing
    repeat (2) wait_xfer_absent();
    rd(sine_feeder_pkg::OFS_SRC, q);
    check("src frozen", q, 32'h000FE063);
    rd(sine_feeder_pkg::OFS_CTRL, q);
    check("disarmed", {31'h0, q[3]}, 32'h0);
  endtask
  task automatic wait_xfer_absent();
    logic [31:0] q;
    repeat (40) @(posedge ref_clk);
    rd(sine_feeder_pkg::OFS_STATUS, q);
    check("stray transfer", {31'h0, q[1]}, 32'h0);
  endtask
  // Clock enable low for 100 cycles must push the next count end back by as much
  task automatic t_freeze();
    logic [31:0] q;
    int t0;
    wr(sine_feeder_pkg::OFS_MASK, 32'h1);
    rd(sine_feeder_pkg::OFS_STATUS, q);
    wait_irq(1'b1);
    t0 = cyc;
    rd(sine_feeder_pkg::OFS_STATUS, q);
    ce <= 1'b0;
    repeat (100) @(posedge ref_clk);
    ce <= 1'b1;
    wait_irq(1'b1);
    check("ce freeze", {31'h0, (cyc - t0) inside {[125:140]}}, 32'h1);
  endtask
  task automatic t_rearm();
    logic [31:0] q;
    wr(sine_feeder_pkg::OFS_SRC, 32'h000FE000);
    wr(sine_feeder_pkg::OFS_COUNT, 32'h1);
    wr(sine_feeder_pkg::OFS_CTRL, 32'hF);
    wait_xfer(q);
    rd(sine_feeder_pkg::OFS_CONV, q);
    check("rearmed value", q, {24'h0, tab[0]});
    wr(sine_feeder_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    check("output off", {24'h0, level}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_table();
    t_timer();
    t_stream();
    t_freeze();
    t_rearm();
    complete_run();
  end
  // Watchdog well beyond the few thousand cycles the run needs
  initial begin
    #(20000 * 10);
    mismatches++;
    complete_run();
  end
endmodule
